// >>> rtc_pkg.sv
// Shared constants, types and state codes for the clock front end.
// Operation
// R1: Top sixteen addresses hit clock registers; RAM enables blocked, registers serve access.
// R2: Up to 524,272 RAM locations; all other addresses pass through.
// R3: System ties unused high address pins high for smaller RAMs.
// R4: Two time sets kept: internal counting set and user-visible set.
// R5: Software can freeze and resume transfer of time into visible set.
// R6: Internal set keeps counting while oscillator runs, regardless of visible set.
// R7: Interrupt pin pulls low when time matches programmed alarm values.
// R8: Alarm works on system supply; optional enable fires it on battery.
// R9: Watchdog fires interrupt or reset when host misses the timeout.
// R10: No register or RAM access while power-on reset output is low.
// R11: Register hit forces RAM chip select output high.
// R12: Otherwise chip and output enables copied to RAM outputs after delay.
// R13: Register read with both enables low drives selected byte on data pins.
// R14: Chip enable low with write enable high is a read cycle.
// R15: Reads follow address changes without new enable edges.
// R16: Data pins driven only when both enables active, else released.
// R17: On address change old byte holds briefly, then output is undefined.
// R18: Supply out of tolerance makes chip enable ignored, blocking all access.
// R19: Time held as packed BCD, hours in 24-hour form, with century.
// R20: Calendar rolls month lengths and leap years without software.
// R21: Timebase from crystal or external 32.768kHz oscillator on first input.
// R22: Reset output stays low 40ms to 200ms after supply returns.
// R23: Chip and write enables both low write; host holds address stable.
// R24: Register hit when all address bits above lowest four are high.
`default_nettype none
package rtc_pkg;
	localparam int ADDR_W = 19;
	localparam int SEL_W = 4;
	localparam int NREG = 16;
	// Register indices within the top sixteen locations.
	localparam logic [3:0] IDX_FLAGS = 4'h0;
	localparam logic [3:0] IDX_ASEC = 4'h2;
	localparam logic [3:0] IDX_AMIN = 4'h3;
	localparam logic [3:0] IDX_AHOUR = 4'h4;
	localparam logic [3:0] IDX_ADATE = 4'h5;
	localparam logic [3:0] IDX_INTS = 4'h6;
	localparam logic [3:0] IDX_WDOG = 4'h7;
	localparam logic [3:0] IDX_CTRL = 4'h8;
	localparam logic [3:0] IDX_SEC = 4'h9;
	localparam logic [3:0] IDX_MIN = 4'hA;
	localparam logic [3:0] IDX_HOUR = 4'hB;
	localparam logic [3:0] IDX_DAY = 4'hC;
	localparam logic [3:0] IDX_DATE = 4'hD;
	localparam logic [3:0] IDX_MONTH = 4'hE;
	localparam logic [3:0] IDX_YEAR = 4'hF;
	// Field positions.
	localparam int BIT_W = 7;
	localparam int BIT_R = 6;
	localparam int BIT_OSC = 7;
	localparam int BIT_AE = 7;
	localparam int BIT_ABE = 5;
	localparam int BIT_WDS = 7;
	localparam int BIT_WF = 7;
	localparam int BIT_AF = 6;
	localparam int BIT_AM = 7;
	// Reset values of the calendar: 2000-01-01, day 1.
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] CENT_INIT = 8'h20;
	localparam logic [7:0] MAX_SEC = 8'h59;
	localparam logic [7:0] MAX_HOUR = 8'h23;
	localparam logic [7:0] MAX_DAY = 8'h07;
	localparam logic [7:0] MAX_MONTH = 8'h12;
	localparam logic [7:0] MAX_YEAR = 8'h99;
	localparam logic [7:0] MAX_CENT = 8'h39;
	// Timing.
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_HZ = 32_768;
	localparam int POR_MS = 40;
	localparam int POR_CYC = CLK_HZ / 1000 * POR_MS;
	localparam int HOLD_NS = 50;
	localparam int HOLD_CYC = (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int WD_UNIT_HZ = 16;
	typedef enum logic [1:0] {
		POR_IDLE = 2'b00,
		POR_HOLD = 2'b01,
		POR_RUN = 2'b10
	} por_e;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic ce_b;
		logic oe_b;
		logic we_b;
	} bus_s;
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
		logic [7:0] cent;
	} time_s;
	// BCD increment of a packed two-digit byte.
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction
	function automatic logic is_leap(input logic [7:0] yr);
		logic [4:0] bin;
		bin = 5'(yr[7:4] * 4'hA % 5'd4) + 5'(yr[3:0]);
		return bin[1:0] == 2'b00;
	endfunction
	function automatic logic [7:0] month_len(input logic [7:0] mo,
			input logic [7:0] yr);
		unique case (mo)
			8'h02: return is_leap(yr) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> rtc_calendar.sv
// Internal counting time set with BCD calendar rollover.
`default_nettype none
module rtc_calendar import rtc_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic tick,
	input wire logic load,
	input wire time_s load_val,
	output time_s now
);
	time_s cur_r, cur_nxt;
	always_comb begin
		cur_nxt = cur_r;
		if (load) begin
			cur_nxt = load_val;
		end else if (tick) begin // [R6] [R19] [R20]
			cur_nxt.sec = bcd_inc(cur_r.sec);
			if (cur_r.sec == MAX_SEC) begin
				cur_nxt.sec = BCD_ZERO;
				cur_nxt.min = bcd_inc(cur_r.min);
				if (cur_r.min == MAX_SEC) begin
					cur_nxt.min = BCD_ZERO;
					cur_nxt.hour = bcd_inc(cur_r.hour);
					if (cur_r.hour == MAX_HOUR) begin
						cur_nxt.hour = BCD_ZERO;
						cur_nxt.day = (cur_r.day == MAX_DAY) ? BCD_ONE :
							bcd_inc(cur_r.day);
						cur_nxt.date = bcd_inc(cur_r.date);
						if (cur_r.date == month_len(cur_r.month, cur_r.year)) begin
							cur_nxt.date = BCD_ONE;
							cur_nxt.month = bcd_inc(cur_r.month);
							if (cur_r.month == MAX_MONTH) begin
								cur_nxt.month = BCD_ONE;
								cur_nxt.year = bcd_inc(cur_r.year);
								if (cur_r.year == MAX_YEAR) begin
									cur_nxt.year = BCD_ZERO;
									cur_nxt.cent = (cur_r.cent == MAX_CENT) ?
										BCD_ZERO : bcd_inc(cur_r.cent);
								end
							end
						end
					end
				end
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cur_r <= '{BCD_ZERO, BCD_ZERO, BCD_ZERO, BCD_ONE, BCD_ONE,
				BCD_ONE, BCD_ZERO, CENT_INIT};
		else if (ce)
			cur_r <= cur_nxt;
	end
	assign now = cur_r;
endmodule
`default_nettype wire

// >>> rtc_por.sv
// Power-on reset hold-off timer.
`default_nettype none
module rtc_por import rtc_pkg::*; #(
	parameter int HOLD = POR_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic supply_ok,
	output logic por_active
);
	por_e st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			POR_IDLE: if (supply_ok) begin
				st_nxt = POR_HOLD;
				cnt_nxt = '0;
			end
			POR_HOLD: begin // [R22]
				cnt_nxt = cnt_r + 32'd1;
				if (!supply_ok)
					st_nxt = POR_IDLE;
				else if (cnt_r == 32'(HOLD - 1))
					st_nxt = POR_RUN;
			end
			POR_RUN: if (!supply_ok)
				st_nxt = POR_IDLE;
			default: st_nxt = POR_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= POR_IDLE;
			cnt_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	assign por_active = (st_r != POR_RUN);
endmodule
`default_nettype wire

// >>> rtc_sram_bus_decoder.sv
// Top level: bus decode, register file, alarm, watchdog and RAM pass-through.
`default_nettype none
module rtc_sram_bus_decoder import rtc_pkg::*; #(
	parameter int POR_HOLD = POR_CYC,
	parameter int TICK_DIV = TICK_HZ
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] address_pins,
	input wire logic chip_en_b,
	input wire logic out_en_b,
	input wire logic write_en_b,
	input wire logic [7:0] data_pins_in,
	output logic [7:0] data_pins_out,
	output logic data_pins_oe,
	input wire logic supply_ok,
	input wire logic on_battery,
	input wire logic crystal_in,
	output logic crystal_out,
	output logic ram_chip_select_out,
	output logic ram_output_gate_out,
	output logic alarm_irq_freqtest_out,
	output logic alarm_irq_oe,
	output logic reset_out,
	output logic reset_oe
);
	// =========================================================
	// Pin synchronisers
	// =========================================================
	bus_s bus_m_r, bus_r;
	logic [7:0] din_m_r, din_r;
	logic [2:0] xin_m_r, xin_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_m_r <= '{'0, 1'b1, 1'b1, 1'b1};
			bus_r <= '{'0, 1'b1, 1'b1, 1'b1};
			din_m_r <= '0;
			din_r <= '0;
			xin_m_r <= '0;
			xin_r <= '0;
		end else if (clk_en) begin
			bus_m_r <= '{address_pins, chip_en_b, out_en_b, write_en_b};
			bus_r <= bus_m_r;
			din_m_r <= data_pins_in;
			din_r <= din_m_r;
			xin_m_r <= {supply_ok, on_battery, crystal_in};
			xin_r <= xin_m_r;
		end
	end
	logic supply_s, batt_s, xtal_s;
	assign {supply_s, batt_s, xtal_s} = xin_r;
	// The oscillator amplifier is off-chip here; the output only idles low.
	assign crystal_out = 1'b0;

	// =========================================================
	// Power-on reset and access gating
	// =========================================================
	logic por_active;
	rtc_por #(.HOLD(POR_HOLD)) u_por (
		.clk(clk),
		.rst_b(rst_b),
		.ce(clk_en),
		.supply_ok(supply_s),
		.por_active(por_active)
	);
	logic access_ok, hit, cs, rd, wr;
	assign access_ok = supply_s && !por_active; // [R10] [R18]
	assign hit = &bus_r.addr[ADDR_W-1:SEL_W]; // [R1] [R24]
	assign cs = access_ok && !bus_r.ce_b;
	assign rd = cs && bus_r.we_b; // [R14]
	assign wr = cs && !bus_r.we_b && hit; // [R23]

	// =========================================================
	// Crystal tick (one pulse per second)
	// =========================================================
	logic xtal_d_r, xtal_d_nxt, sec_tick;
	logic [15:0] div_r, div_nxt;
	always_comb begin // [R21]
		xtal_d_nxt = xtal_s;
		div_nxt = div_r;
		sec_tick = 1'b0;
		if (xtal_s && !xtal_d_r) begin
			if (div_r == 16'(TICK_DIV - 1)) begin
				div_nxt = '0;
				sec_tick = 1'b1;
			end else begin
				div_nxt = div_r + 16'd1;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xtal_d_r <= 1'b0;
			div_r <= '0;
		end else if (clk_en) begin
			xtal_d_r <= xtal_d_nxt;
			div_r <= div_nxt;
		end
	end

	// =========================================================
	// Register file and time sets
	// =========================================================
	logic [7:0] regs_r [NREG];
	logic [7:0] regs_nxt [NREG];
	time_s now, load_val;
	logic load, osc_run, wr_d_r;
	logic af_set, wf_set, wd_kick;
	assign osc_run = !regs_r[IDX_SEC][BIT_OSC];
	assign load_val = '{regs_r[IDX_SEC] & 8'h7F, regs_r[IDX_MIN],
		regs_r[IDX_HOUR], regs_r[IDX_DAY] & 8'h07, regs_r[IDX_DATE],
		regs_r[IDX_MONTH], regs_r[IDX_YEAR], regs_r[IDX_CTRL] & 8'h3F};
	// Only a write taking W from one to zero commits the visible set, so
	// setting R alone never rewinds the counter or swallows a tick.
	assign load = wr_d_r && !regs_r[IDX_CTRL][BIT_W] && clk_en;
	rtc_calendar u_cal (
		.clk(clk),
		.rst_b(rst_b),
		.ce(clk_en),
		.tick(sec_tick && osc_run),
		.load(load),
		.load_val(load_val),
		.now(now)
	);
	logic frozen;
	assign frozen = regs_r[IDX_CTRL][BIT_W] || regs_r[IDX_CTRL][BIT_R];
	logic [3:0] sel;
	assign sel = bus_r.addr[SEL_W-1:0];
	logic rd_d_r;
	logic [3:0] rd_sel_r;
	logic rd_end;
	always_comb begin
		for (int i = 0; i < NREG; i++)
			regs_nxt[i] = regs_r[i];
		if (!frozen) begin // [R4] [R5]
			regs_nxt[IDX_SEC] = {regs_r[IDX_SEC][BIT_OSC], now.sec[6:0]};
			regs_nxt[IDX_MIN] = now.min;
			regs_nxt[IDX_HOUR] = now.hour;
			regs_nxt[IDX_DAY] = {regs_r[IDX_DAY][7:3], now.day[2:0]};
			regs_nxt[IDX_DATE] = now.date;
			regs_nxt[IDX_MONTH] = now.month;
			regs_nxt[IDX_YEAR] = now.year;
			regs_nxt[IDX_CTRL] = {regs_r[IDX_CTRL][7:6], now.cent[5:0]};
		end
		if (wr && sel != IDX_FLAGS)
			regs_nxt[sel] = din_r;
		// Flags clear on a read ending; a fresh event in that cycle wins.
		if (rd_end && hit && rd_sel_r == IDX_FLAGS) begin
			regs_nxt[IDX_FLAGS][BIT_AF] = 1'b0;
			regs_nxt[IDX_FLAGS][BIT_WF] = 1'b0;
		end
		if (af_set)
			regs_nxt[IDX_FLAGS][BIT_AF] = 1'b1;
		if (wf_set)
			regs_nxt[IDX_FLAGS][BIT_WF] = 1'b1;
		regs_nxt[IDX_FLAGS][5:0] = '0;
	end
	assign rd_end = rd_d_r && !(rd && hit);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NREG; i++)
				regs_r[i] <= BCD_ZERO;
			wr_d_r <= 1'b0;
			rd_d_r <= 1'b0;
			rd_sel_r <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NREG; i++)
				regs_r[i] <= regs_nxt[i];
			wr_d_r <= wr && sel == IDX_CTRL
				&& regs_r[IDX_CTRL][BIT_W] && !din_r[BIT_W];
			rd_d_r <= rd && hit;
			rd_sel_r <= sel;
		end
	end

	// =========================================================
	// Alarm match
	// =========================================================
	function automatic logic field_ok(input logic [7:0] a, input logic [7:0] t,
			input logic [7:0] m);
		return a[BIT_AM] || ((a & m) == (t & m));
	endfunction
	logic match_now, match_d_r;
	assign match_now = field_ok(regs_r[IDX_ASEC], {1'b0, now.sec[6:0]}, 8'h7F)
		&& field_ok(regs_r[IDX_AMIN], now.min, 8'h7F)
		&& field_ok(regs_r[IDX_AHOUR], now.hour, 8'h3F)
		&& field_ok(regs_r[IDX_ADATE], now.date, 8'h3F);
	// Only the rising edge of a match counts, so one match sets one flag.
	assign af_set = match_now && !match_d_r
		&& (!batt_s || regs_r[IDX_INTS][BIT_ABE]); // [R7] [R8]
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			match_d_r <= 1'b0;
		else if (clk_en)
			match_d_r <= match_now;
	end

	// =========================================================
	// Watchdog
	// =========================================================
	logic [31:0] wd_cnt_r, wd_cnt_nxt, wd_limit;
	logic wd_rst_r, wd_rst_nxt;
	// Counts in sixteenths of a second: BMB sets units, RB scales.
	assign wd_limit = 32'(regs_r[IDX_WDOG][6:2]) * (32'd1 <<
		(2 * regs_r[IDX_WDOG][1:0])) * 32'(TICK_DIV / WD_UNIT_HZ);
	assign wd_kick = wr && sel == IDX_WDOG;
	always_comb begin // [R9]
		wd_cnt_nxt = wd_cnt_r;
		wd_rst_nxt = wd_rst_r;
		wf_set = 1'b0;
		if (wd_kick || wd_limit == '0) begin
			wd_cnt_nxt = '0;
			wd_rst_nxt = 1'b0;
		end else if (xtal_s && !xtal_d_r) begin
			wd_cnt_nxt = wd_cnt_r + 32'd1;
			if (wd_cnt_r + 32'd1 >= wd_limit) begin
				wd_cnt_nxt = '0;
				wf_set = 1'b1;
				wd_rst_nxt = regs_r[IDX_WDOG][BIT_WDS];
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_cnt_r <= '0;
			wd_rst_r <= 1'b0;
		end else if (clk_en) begin
			wd_cnt_r <= wd_cnt_nxt;
			wd_rst_r <= wd_rst_nxt;
		end
	end

	// =========================================================
	// Data pins and RAM pass-through
	// =========================================================
	logic [3:0] hold_r, hold_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic [ADDR_W-1:0] addr_d_r;
	always_comb begin // [R13] [R15] [R17]
		hold_nxt = hold_r;
		dout_nxt = dout_r;
		if (bus_r.addr != addr_d_r)
			hold_nxt = 4'(HOLD_CYC);
		else if (hold_r != '0)
			hold_nxt = hold_r - 4'd1;
		else
			dout_nxt = regs_r[sel];
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_r <= '0;
			dout_r <= '0;
			addr_d_r <= '0;
		end else if (clk_en) begin
			hold_r <= hold_nxt;
			dout_r <= dout_nxt;
			addr_d_r <= bus_r.addr;
		end
	end
	assign data_pins_out = dout_r;
	assign data_pins_oe = rd && hit && !bus_r.oe_b; // [R16]
	assign ram_chip_select_out = !(cs && !hit); // [R11] [R12] [R2]
	assign ram_output_gate_out = !(access_ok && !hit) || bus_r.oe_b; // [R12]
	// Open-drain pins: low is driven, high is released.
	assign alarm_irq_freqtest_out = 1'b0;
	assign alarm_irq_oe = (regs_r[IDX_FLAGS][BIT_AF]
		&& regs_r[IDX_INTS][BIT_AE])
		|| (regs_r[IDX_FLAGS][BIT_WF] && !regs_r[IDX_WDOG][BIT_WDS]);
	assign reset_out = 1'b0;
	assign reset_oe = por_active || wd_rst_r;
endmodule
`default_nettype wire

// >>> rtc_sram_bus_decoder_props.sv
// Pin-level checker for the clock front end, bound to its top module.
`default_nettype none
module rtc_sram_bus_decoder_props import rtc_pkg::*; #(
	parameter int POR_HOLD = POR_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] address_pins,
	input wire logic chip_en_b,
	input wire logic out_en_b,
	input wire logic write_en_b,
	input wire logic supply_ok,
	input wire logic data_pins_oe,
	input wire logic ram_chip_select_out,
	input wire logic ram_output_gate_out,
	input wire logic alarm_irq_freqtest_out,
	input wire logic reset_out,
	input wire logic reset_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] age_r, age_nxt;
	int up_r, up_nxt;
	logic hit, ok, sel_hit, rd_hit, pass;
	// The synchroniser needs three edges before its outputs mean anything.
	assign ok = age_r == 2'h3;
	assign hit = &address_pins[ADDR_W-1:SEL_W];
	assign sel_hit = hit && !chip_en_b && !out_en_b;
	assign rd_hit = sel_hit && write_en_b && supply_ok;
	assign pass = !hit && supply_ok;
	always_comb begin
		age_nxt = ok ? age_r : age_r + 2'h1;
		up_nxt = supply_ok ? up_r + 1 : 0;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			age_r <= 2'h0;
			up_r <= 0;
		end else begin
			age_r <= age_nxt;
			up_r <= up_nxt;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Properties
	property p_hit_block;
		ok && $past(hit, 2) |-> ram_chip_select_out && ram_output_gate_out;
	endproperty
	a_hit_block: assert property (p_hit_block)
		else $error("RAM enabled on a register hit");
	property p_pass_cs;
		ok && !reset_oe && $past(pass, 2)
			|-> ram_chip_select_out == $past(chip_en_b, 2);
	endproperty
	a_pass_cs: assert property (p_pass_cs)
		else $error("RAM chip select not copied");
	property p_pass_og;
		ok && !reset_oe && $past(pass, 2)
			|-> ram_output_gate_out == $past(out_en_b, 2);
	endproperty
	a_pass_og: assert property (p_pass_og)
		else $error("RAM output gate not copied");
	property p_refuse;
		reset_oe |-> ram_chip_select_out && !data_pins_oe;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("access taken while reset is out");
	property p_supply;
		ok && !$past(supply_ok, 2) |-> ram_chip_select_out && !data_pins_oe;
	endproperty
	a_supply: assert property (p_supply)
		else $error("access taken with supply low");
	property p_no_drive;
		data_pins_oe |-> $past(sel_hit, 2);
	endproperty
	a_no_drive: assert property (p_no_drive)
		else $error("data pins driven without both enables");
	property p_drive;
		ok && !reset_oe && $past(rd_hit, 2) |-> data_pins_oe;
	endproperty
	a_drive: assert property (p_drive)
		else $error("register read not driven");
	property p_por_min;
		$fell(reset_oe) |-> up_r >= POR_HOLD;
	endproperty
	a_por_min: assert property (p_por_min)
		else $error("reset released too early");
	property p_por_max;
		up_r > POR_HOLD + 8 |-> !reset_oe;
	endproperty
	a_por_max: assert property (p_por_max)
		else $error("reset held too long");
	property p_pins;
		!alarm_irq_freqtest_out && !reset_out;
	endproperty
	a_pins: assert property (p_pins)
		else $error("open drain pin driven high");
	c_read: cover property (data_pins_oe);
	c_release: cover property ($fell(reset_oe));
	c_ram: cover property (!ram_chip_select_out);
endmodule
bind rtc_sram_bus_decoder rtc_sram_bus_decoder_props #(
	.POR_HOLD(POR_HOLD)) i_rtc_sram_bus_decoder_props (.clk, .rst_b,
	.address_pins, .chip_en_b, .out_en_b, .write_en_b, .supply_ok,
	.data_pins_oe, .ram_chip_select_out, .ram_output_gate_out,
	.alarm_irq_freqtest_out, .reset_out, .reset_oe);
`default_nettype wire

// >>> rtc_host_model.sv
// Host processor model on the asynchronous byte-wide bus.
`default_nettype none
module rtc_host_model import rtc_pkg::*; (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output bus_s bus,
	output logic [7:0] wdata,
	output logic wdata_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Long enough for the synchroniser, the byte register and its hold.
	localparam int HOLD = 8;
	initial begin
		bus = '{addr: '1, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
		wdata = 8'h00;
		wdata_oe = 1'b0;
	end
	// With k set the enables stay low, so the next call ripples.
	task automatic acc(input logic [ADDR_W-1:0] a, input logic w,
			input logic [7:0] d, input logic o, input logic k,
			output logic [7:0] q);
		@(posedge clk);
		bus.addr <= a;
		bus.ce_b <= 1'b0;
		bus.oe_b <= ~o;
		bus.we_b <= ~w;
		wdata <= d;
		wdata_oe <= w;
		repeat (HOLD) @(posedge clk);
		q = rdata;
		if (!k) begin
			bus.ce_b <= 1'b1;
			bus.oe_b <= 1'b1;
			bus.we_b <= 1'b1;
			wdata_oe <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> rtc_sram_bus_decoder_bench.sv
// Self-checking bench for the clock front end and RAM pass-through.
`default_nettype none
module rtc_sram_bus_decoder_bench import rtc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PH = 20;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic supply_ok = 1'b0;
	logic xtal = 1'b0;
	logic [7:0] float_r = 8'h5A;
	bus_s bus;
	logic [7:0] wd, dout, dbus, q;
	logic wd_oe, doe, cs, og, irq, irq_oe, rst_o, rst_oe, xo;
	int miscompares = 0;
	int check_count = 0;
	always #12.5 clk = ~clk;
	// Sixteen rising crystal edges every 128 cycles.
	always begin
		repeat (4) @(posedge clk);
		xtal <= ~xtal;
	end
	// A released data bus must never look like a stale byte.
	always @(posedge clk) float_r <= ~float_r;
	assign dbus = wd_oe ? wd : doe ? dout : float_r;
	rtc_sram_bus_decoder #(.POR_HOLD(PH), .TICK_DIV(16))
		i_rtc_sram_bus_decoder (.clk, .rst_b, .clk_en(1'b1),
		.address_pins(bus.addr), .chip_en_b(bus.ce_b),
		.out_en_b(bus.oe_b), .write_en_b(bus.we_b), .data_pins_in(dbus),
		.data_pins_out(dout), .data_pins_oe(doe), .supply_ok,
		.on_battery(1'b0), .crystal_in(xtal), .crystal_out(xo),
		.ram_chip_select_out(cs), .ram_output_gate_out(og),
		.alarm_irq_freqtest_out(irq), .alarm_irq_oe(irq_oe),
		.reset_out(rst_o), .reset_oe(rst_oe));
	rtc_host_model i_rtc_host_model (.clk, .rdata(dbus), .bus,
		.wdata(wd), .wdata_oe(wd_oe));
	// ==========================================================
	// Helpers
	function automatic logic [ADDR_W-1:0] ra(input logic [3:0] i);
		return {{(ADDR_W-SEL_W){1'b1}}, i};
	endfunction
	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		i_rtc_host_model.acc(ra(i), 1'b1, d, 1'b0, 1'b0, q);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic k);
		i_rtc_host_model.acc(a, 1'b0, 8'h00, 1'b1, k, q);
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_por;
		for (int n = 0; n < 100 && rst_oe !== 1'b0; n++)
			@(posedge clk);
		#1;
		chk(rst_oe, 1'b0);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_por;
		realtime t0;
		chk(rst_oe, 1'b1);
		supply_ok <= 1'b1;
		t0 = $realtime;
		rd(ra(IDX_SEC), 1'b1);
		chk(doe, 1'b0);
		chk(cs, 1'b1);
		wait_por();
		chk(($realtime - t0) / 25.0 >= PH, 1'b1);
		repeat (3) @(posedge clk);
		chk(doe, 1'b1);
		rd(ra(IDX_SEC), 1'b0);
	endtask
	task automatic t_decode;
		logic [ADDR_W-1:0] al [5] = '{19'h00123, 19'h7FFEF, 19'h3FFF5,
			19'h7FFF0, 19'h7FFFF};
		logic h;
		foreach (al[i]) for (int o = 0; o < 2; o++) begin
			h = &al[i][ADDR_W-1:SEL_W];
			i_rtc_host_model.acc(al[i], 1'b0, 8'h00, o[0], 1'b1, q);
			chk(cs, h);
			chk(og, h | !o[0]);
			chk(doe, h & o[0]);
		end
		rd(19'h00123, 1'b0);
	endtask
	task automatic t_regs;
		wr(IDX_ASEC, 8'h45);
		wr(IDX_AMIN, 8'h12);
		rd(ra(IDX_ASEC), 1'b1);
		chk(q, 8'h45);
		rd(ra(IDX_AMIN), 1'b1);
		chk(q, 8'h12);
		rd(ra(IDX_ASEC), 1'b0);
		chk(q, 8'h45);
	endtask
	task automatic t_time;
		logic [7:0] a;
		wr(IDX_CTRL, 8'hA0);
		wr(IDX_SEC, 8'h00);
		wr(IDX_CTRL, 8'h20);
		repeat (256) @(posedge clk);
		wr(IDX_CTRL, 8'h60);
		rd(ra(IDX_SEC), 1'b0);
		a = q;
		chk(a != 8'h00 && a <= 8'h09, 1'b1);
		repeat (300) @(posedge clk);
		rd(ra(IDX_SEC), 1'b0);
		chk(q, a);
		wr(IDX_CTRL, 8'h20);
		repeat (300) @(posedge clk);
		wr(IDX_CTRL, 8'h60);
		rd(ra(IDX_SEC), 1'b0);
		chk(q > a + 8'h03 && q <= 8'h09, 1'b1);
		wr(IDX_CTRL, 8'h20);
	endtask
	task automatic t_supply;
		supply_ok <= 1'b0;
		rd(19'h00123, 1'b1);
		chk(cs, 1'b1);
		chk(og, 1'b1);
		rd(19'h00123, 1'b0);
		supply_ok <= 1'b1;
		wait_por();
	endtask
	task automatic t_wdog;
		wr(IDX_WDOG, 8'h04);
		for (int n = 0; n < 400 && irq_oe !== 1'b1; n++)
			@(posedge clk);
		chk(irq_oe, 1'b1);
		chk(rst_oe, 1'b0);
		wr(IDX_WDOG, 8'h00);
		rd(ra(IDX_FLAGS), 1'b0);
		chk(q[7], 1'b1);
		repeat (4) @(posedge clk);
		chk(irq_oe, 1'b0);
	endtask
	task automatic t_alarm;
		wr(IDX_INTS, 8'h80);
		wr(IDX_ASEC, 8'h80);
		wr(IDX_AMIN, 8'h80);
		wr(IDX_AHOUR, 8'h80);
		wr(IDX_ADATE, 8'h80);
		chk(irq_oe, 1'b1);
		rd(ra(IDX_FLAGS), 1'b0);
		chk(q[6], 1'b1);
		repeat (4) @(posedge clk);
		chk(irq_oe, 1'b0);
		wr(IDX_INTS, 8'h00);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_por();
		t_decode();
		t_regs();
		t_time();
		t_supply();
		t_wdog();
		t_alarm();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule
`default_nettype wire
